/* File: core/dcfi_pkg.sv */
`default_nettype none
package dcfi_pkg;

  // Converter code word layout
  localparam int        CODE_W     = 12;
  localparam int        WORD_W     = 16;
  localparam int        LEVEL_W    = 13;
  localparam logic [11:0] CODE_MID = 12'h800;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CONFIG_REG_ONE   = 8'h00;
  localparam logic [7:0] ADDR_CONFIG_REG_TWO   = 8'h04;
  localparam logic [7:0] ADDR_CONFIG_REG_THREE   = 8'h08;
  localparam logic [7:0] ADDR_CNTCMD = 8'h0C;
  localparam logic [7:0] ADDR_CNT1LD = 8'h10;
  localparam logic [7:0] ADDR_IRQ1CL = 8'h14;
  localparam logic [7:0] ADDR_IRQ2CL = 8'h18;
  localparam logic [7:0] ADDR_DMATCL = 8'h1C;
  localparam logic [7:0] ADDR_QCLR   = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_CODE0  = 8'h40;
  localparam int         ADDR_LSB    = 2;

  // Field layouts and reset values
  localparam logic [15:0] CFG_RESET     = 16'h0000;
  localparam logic [15:0] CONFIG_REG_ONE_IRQ_MASK = 16'h00F0;
  localparam logic [15:0] CONFIG_REG_ONE_DMA_MASK = 16'h0300;
  localparam int          CONFIG_REG_THREE_DIO_BIT  = 0;
  localparam int          CONFIG_REG_THREE_CAL_BIT  = 1;
  localparam int          CMD_SEL_HI    = 7;
  localparam int          CMD_SEL_LO    = 6;
  localparam int          CMD_MODE_HI   = 3;
  localparam int          CMD_MODE_LO   = 1;
  localparam logic [2:0]  MODE_LOW_OUT  = 3'h0;
  localparam int          NUM_CNT       = 3;

  // Register selector
  typedef enum logic [3:0] {
    SEL_CONFIG_REG_ONE   = 4'h0,
    SEL_CONFIG_REG_TWO   = 4'h1,
    SEL_CONFIG_REG_THREE   = 4'h2,
    SEL_CNTCMD = 4'h3,
    SEL_CNT1LD = 4'h4,
    SEL_IRQ1CL = 4'h5,
    SEL_IRQ2CL = 4'h6,
    SEL_DMATCL = 4'h7,
    SEL_QCLR   = 4'h8,
    SEL_STATUS = 4'h9,
    SEL_CODE   = 4'hA,
    SEL_NONE   = 4'hF
  } dcfi_sel_t;

  // APB request and answer
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } dcfi_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dcfi_apb_rsp_t;

  // Strobes toward the rest of the board
  typedef struct packed {
    logic queueClear;
    logic irqOneClear;
    logic irqTwoClear;
    logic dmaTcClear;
  } dcfi_strobe_t;

endpackage
`default_nettype wire

/* File: core/dcfi_chan.sv */
`default_nettype none
module dcfi_chan
(
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              rst_n,
  // Code and format
  input  wire logic [dcfi_pkg::CODE_W-1:0]       code,
  input  wire logic                              twosComp,
  input  wire logic                              bipolar,
  // Level in reference steps
  output logic signed [dcfi_pkg::LEVEL_W-1:0]    level
);

  typedef struct packed {
    logic signed [dcfi_pkg::LEVEL_W-1:0] level;
  } dcfi_chan_st_t;

  dcfi_chan_st_t st_q;
  dcfi_chan_st_t st_d;

  localparam logic [dcfi_pkg::LEVEL_W-1:0] MID13 = {1'b0, dcfi_pkg::CODE_MID};

  // Map the 12-bit code onto a signed step count
  always_comb
  begin
    st_d = st_q;
    if (!bipolar)
    begin
      // Unipolar: step is ref/4096; two's complement recentred on mid-scale
      st_d.level = twosComp ? {1'b0, ~code[11], code[10:0]} : {1'b0, code}; // R4
    end
    else if (twosComp)
    begin
      st_d.level = {code[11], code}; // R6
    end
    else
    begin
      st_d.level = {1'b0, code} - MID13; // R5
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign level = st_q.level;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_unipolar_scale: assert property (!bipolar && !twosComp |=> level == {1'b0, $past(code)}) // R4
    else $error("unipolar level not equal to code");
  a_offset_binary: assert property (bipolar && !twosComp && code == dcfi_pkg::CODE_MID |=> level == '0) // R5
    else $error("offset binary mid code not zero");
  a_twos_signed: assert property (bipolar && twosComp |=> level == {$past(code[11]), $past(code)}) // R6
    else $error("two's complement level not sign extended");

endmodule
`default_nettype wire

/* File: core/dcfi_core.sv */
`default_nettype none
// Operation
// R1 - Two's complement upper bits copy code MSB
// R2 - Host writes zero upper bits in binary
// R3 - Code field bits 11:0, unsigned or signed
// R4 - Unipolar: zero code zero, step ref/4096
// R5 - Bipolar binary: offset, 2048 is zero
// R6 - Bipolar two's complement: signed code direct
// R7 - Writes replace whole register, no readback
// R8 - Host keeps shadow copies of registers
// R9 - Power-up clears all three config registers
// R10 - Power-up loads mid-scale into every channel
// R11 - Host init: config, counter command writes
// R12 - Host init: queue clear, clears, config
// R13 - After init: queue empty, irq/DMA off
// R14 - After init: lines hi-Z, cal off, counters high
// R15 - Reading queue clear empties the queue
module dcfi_core
#(
  parameter int NCH = 10
)
(
  // Clock and reset
  input  wire logic                                            sys_clk,
  input  wire logic                                            rst_n,
  // APB slave
  input  wire dcfi_pkg::dcfi_apb_req_t                         apbReq,
  output dcfi_pkg::dcfi_apb_rsp_t                              apbRsp,
  // Polarity straps per channel, from pins
  input  wire logic [NCH-1:0]                                  bipolarPin,
  // Converter levels
  output logic signed [NCH-1:0][dcfi_pkg::LEVEL_W-1:0]         dacLevel,
  // Board control
  output var logic                                             irqEnable,
  output var logic                                             dmaEnable,
  output var logic                                             dioOutEn_n,
  output var logic                                             calEnable,
  output var logic                                             counterOneOut,
  output var logic                                             counterTwoOut,
  output var dcfi_pkg::dcfi_strobe_t                           strobes
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [15:0]                              config_reg_one;
    logic [15:0]                              config_reg_two;
    logic [15:0]                              config_reg_three;
    logic [NCH-1:0][dcfi_pkg::CODE_W-1:0]     code;
    logic [dcfi_pkg::NUM_CNT-1:0]             cntOut;
    logic [7:0]                               cnt1Load;
    logic [NCH-1:0]                           sync1;
    logic [NCH-1:0]                           sync2;
    logic [NCH-1:0]                           sync3;
    logic [NCH-1:0]                           bipolar;
    logic                                     irqEn;
    logic                                     dmaEn;
    logic                                     dioOe_n;
    logic                                     calEn;
    dcfi_pkg::dcfi_strobe_t                   strobe;
    dcfi_pkg::dcfi_apb_rsp_t                  rsp;
  } dcfi_core_st_t;

  dcfi_core_st_t st_q;
  dcfi_core_st_t st_d;

  localparam logic [7:0] CODE_SPAN = 8'(NCH << dcfi_pkg::ADDR_LSB);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic dcfi_pkg::dcfi_sel_t decode(input logic [7:0] a);
    dcfi_pkg::dcfi_sel_t s;
    s = dcfi_pkg::SEL_NONE;
    case (a)
      dcfi_pkg::ADDR_CONFIG_REG_ONE:   s = dcfi_pkg::SEL_CONFIG_REG_ONE;
      dcfi_pkg::ADDR_CONFIG_REG_TWO:   s = dcfi_pkg::SEL_CONFIG_REG_TWO;
      dcfi_pkg::ADDR_CONFIG_REG_THREE:   s = dcfi_pkg::SEL_CONFIG_REG_THREE;
      dcfi_pkg::ADDR_CNTCMD: s = dcfi_pkg::SEL_CNTCMD;
      dcfi_pkg::ADDR_CNT1LD: s = dcfi_pkg::SEL_CNT1LD;
      dcfi_pkg::ADDR_IRQ1CL: s = dcfi_pkg::SEL_IRQ1CL;
      dcfi_pkg::ADDR_IRQ2CL: s = dcfi_pkg::SEL_IRQ2CL;
      dcfi_pkg::ADDR_DMATCL: s = dcfi_pkg::SEL_DMATCL;
      dcfi_pkg::ADDR_QCLR:   s = dcfi_pkg::SEL_QCLR;
      dcfi_pkg::ADDR_STATUS: s = dcfi_pkg::SEL_STATUS;
      default:
      begin
        if (a >= dcfi_pkg::ADDR_CODE0 && a < dcfi_pkg::ADDR_CODE0 + CODE_SPAN && a[1:0] == 2'h0)
          s = dcfi_pkg::SEL_CODE;
      end
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  dcfi_pkg::dcfi_sel_t sel;
  logic                access;
  logic                commit;
  logic [7:0]          chIdx;
  logic [1:0]          cntSel;

  assign sel    = decode(apbReq.paddr);
  assign access = apbReq.psel && apbReq.penable && !st_q.rsp.pready;
  assign commit = apbReq.psel && apbReq.penable && st_q.rsp.pready;
  assign chIdx  = (apbReq.paddr - dcfi_pkg::ADDR_CODE0) >> dcfi_pkg::ADDR_LSB;
  assign cntSel = apbReq.pwdata[dcfi_pkg::CMD_SEL_HI:dcfi_pkg::CMD_SEL_LO];

  always_comb
  begin
    st_d = st_q;
    st_d.strobe = '0;

    // Pin straps: three flops, a change counts once stages two and three agree
    st_d.sync1 = bipolarPin;
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    for (int i = 0; i < NCH; i++)
    begin
      if (st_q.sync2[i] == st_q.sync3[i])
        st_d.bipolar[i] = st_q.sync3[i];
    end

    // APB: one wait cycle, answer in the second access cycle
    st_d.rsp.pready  = access;
    st_d.rsp.prdata  = '0;
    st_d.rsp.pslverr = access && sel == dcfi_pkg::SEL_NONE;
    if (access && !apbReq.pwrite && sel == dcfi_pkg::SEL_STATUS)
    begin
      // Only status reads back; write-only registers return zero
      st_d.rsp.prdata = 32'({st_q.bipolar, st_q.cntOut}); // R7
    end

    // Writes take effect on the edge that completes the transfer
    if (commit && apbReq.pwrite)
    begin
      case (sel)
        dcfi_pkg::SEL_CONFIG_REG_ONE:   st_d.config_reg_one = apbReq.pwdata[15:0]; // R7
        dcfi_pkg::SEL_CONFIG_REG_TWO:   st_d.config_reg_two = apbReq.pwdata[15:0]; // R7
        dcfi_pkg::SEL_CONFIG_REG_THREE:   st_d.config_reg_three = apbReq.pwdata[15:0]; // R7
        dcfi_pkg::SEL_CNTCMD:
        begin
          // A command word sets the addressed counter output to its idle level
          if (cntSel < 2'(dcfi_pkg::NUM_CNT))
            st_d.cntOut[cntSel] = apbReq.pwdata[dcfi_pkg::CMD_MODE_HI:dcfi_pkg::CMD_MODE_LO]
                                  != dcfi_pkg::MODE_LOW_OUT; // R14
        end
        dcfi_pkg::SEL_CNT1LD: st_d.cnt1Load = apbReq.pwdata[7:0];
        dcfi_pkg::SEL_IRQ1CL: st_d.strobe.irqOneClear = 1'b1;
        dcfi_pkg::SEL_IRQ2CL: st_d.strobe.irqTwoClear = 1'b1;
        dcfi_pkg::SEL_DMATCL: st_d.strobe.dmaTcClear = 1'b1;
        dcfi_pkg::SEL_CODE:
        begin
          // Upper four bits are sign copies or zero; only the code is kept
          if (chIdx < 8'(NCH))
            st_d.code[chIdx[3:0]] = apbReq.pwdata[dcfi_pkg::CODE_W-1:0]; // R1 R3
        end
        default: ;
      endcase
    end

    // Reading the queue clear register empties the sample queue
    if (commit && !apbReq.pwrite && sel == dcfi_pkg::SEL_QCLR)
      st_d.strobe.queueClear = 1'b1; // R15

    // Control levels follow the new configuration in the same edge
    st_d.irqEn   = |(st_d.config_reg_one & dcfi_pkg::CONFIG_REG_ONE_IRQ_MASK); // R13
    st_d.dmaEn   = |(st_d.config_reg_one & dcfi_pkg::CONFIG_REG_ONE_DMA_MASK); // R13
    st_d.dioOe_n = !st_d.config_reg_three[dcfi_pkg::CONFIG_REG_THREE_DIO_BIT]; // R14
    st_d.calEn   = st_d.config_reg_three[dcfi_pkg::CONFIG_REG_THREE_CAL_BIT]; // R14
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Reset clears configuration and loads mid-scale codes
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_q         <= '0;
      st_q.config_reg_one    <= dcfi_pkg::CFG_RESET; // R9
      st_q.config_reg_two    <= dcfi_pkg::CFG_RESET; // R9
      st_q.config_reg_three    <= dcfi_pkg::CFG_RESET; // R9
      st_q.code    <= {NCH{dcfi_pkg::CODE_MID}}; // R10
      st_q.cntOut  <= '1;
      st_q.dioOe_n <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel converters

  generate
    for (genvar g = 0; g < NCH; g++)
    begin : gChan
      dcfi_chan uChan
      (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .code     (st_q.code[g]),
        .twosComp (st_q.config_reg_two[g]),
        .bipolar  (st_q.bipolar[g]),
        .level    (dacLevel[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign apbRsp        = st_q.rsp;
  assign irqEnable     = st_q.irqEn;
  assign dmaEnable     = st_q.dmaEn;
  assign dioOutEn_n    = st_q.dioOe_n;
  assign calEnable     = st_q.calEn;
  assign counterOneOut = st_q.cntOut[1];
  assign counterTwoOut = st_q.cntOut[2];
  assign strobes       = st_q.strobe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic wrDone;
  logic rdDone;
  assign wrDone = commit && apbReq.pwrite;
  assign rdDone = commit && !apbReq.pwrite;

  sequence s_access;
    apbReq.psel && apbReq.penable && !apbRsp.pready;
  endsequence

  a_ready_wait: assert property (s_access |=> apbRsp.pready ##1 !apbRsp.pready)
    else $error("ready not one cycle after access");
  a_config_reg_one_whole: assert property (wrDone && sel == dcfi_pkg::SEL_CONFIG_REG_ONE |=> st_q.config_reg_one == $past(apbReq.pwdata[15:0])) // R7
    else $error("config one not fully replaced");
  // Only status reads back; every other read answers zero
  a_wo_noread: assert property (access && !apbReq.pwrite && sel != dcfi_pkg::SEL_STATUS // R7
    |=> apbRsp.prdata == '0)
    else $error("write-only register read back");

  // Reset state
  a_reset_cfg: assert property ($rose(rst_n) |-> st_q.config_reg_one == '0 && st_q.config_reg_two == '0 && st_q.config_reg_three == '0) // R9
    else $error("configuration not cleared by reset");
  a_reset_mid: assert property ($rose(rst_n) |-> st_q.code[0] == dcfi_pkg::CODE_MID) // R10
    else $error("channel not mid-scale after reset");

  // Code word: low twelve bits kept, upper four ignored
  a_code_low: assert property (wrDone && sel == dcfi_pkg::SEL_CODE && chIdx == 8'h00
                               |=> st_q.code[0] == $past(apbReq.pwdata[11:0])) // R1
    else $error("code field not taken from bits 11 to 0");
  a_code_level: assert property (wrDone && sel == dcfi_pkg::SEL_CODE && chIdx == 8'h00 && st_q.config_reg_two[0]
                                 && st_q.bipolar[0] |=> ##1 dacLevel[0][12] == $past(apbReq.pwdata[11], 2)) // R3
    else $error("signed level sign does not follow code MSB");
  a_queue_clear: assert property (rdDone && sel == dcfi_pkg::SEL_QCLR |=> strobes.queueClear ##1 !strobes.queueClear) // R15
    else $error("queue clear strobe not one cycle");
  a_irq_off: assert property (wrDone && sel == dcfi_pkg::SEL_CONFIG_REG_ONE && apbReq.pwdata[15:0] == '0
                              |=> !irqEnable && !dmaEnable) // R13
    else $error("interrupts or DMA left enabled");
  a_dio_hiz: assert property (wrDone && sel == dcfi_pkg::SEL_CONFIG_REG_THREE && apbReq.pwdata[15:0] == '0
                              |=> dioOutEn_n && !calEnable) // R14
    else $error("digital lines driven or calibration on");
  a_counter_high: assert property (wrDone && sel == dcfi_pkg::SEL_CNTCMD && cntSel == 2'h1
                                   && apbReq.pwdata[3:1] != 3'h0 |=> counterOneOut) // R14
    else $error("counter one output not high");
  // Unmapped addresses answer with an error
  a_bad_addr: assert property (access && sel == dcfi_pkg::SEL_NONE |=> apbRsp.pready && apbRsp.pslverr)
    else $error("unmapped address not flagged");

  // Answers stand one cycle; status reads carry the counter levels
  a_err_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
    else $error("error flag without ready");
  a_ready_single: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready held for two cycles");
  a_status_counts: assert property (access && !apbReq.pwrite && sel == dcfi_pkg::SEL_STATUS
    |=> apbRsp.prdata[2:1] == {$past(counterTwoOut), $past(counterOneOut)})
    else $error("status read does not show counter outputs");
  a_bad_write_kept: assert property (wrDone && sel == dcfi_pkg::SEL_NONE
    |=> $stable({st_q.config_reg_one, st_q.config_reg_two, st_q.config_reg_three, st_q.code}))
    else $error("unmapped write changed a register");

  // Clear strobes last one cycle and only after a transfer
  a_irq1_pulse: assert property (wrDone && sel == dcfi_pkg::SEL_IRQ1CL
    |=> strobes.irqOneClear ##1 !strobes.irqOneClear)
    else $error("irq one clear strobe not one cycle");
  a_irq2_pulse: assert property (wrDone && sel == dcfi_pkg::SEL_IRQ2CL
    |=> strobes.irqTwoClear ##1 !strobes.irqTwoClear)
    else $error("irq two clear strobe not one cycle");
  a_strobe_quiet: assert property (!commit |=> strobes == '0)
    else $error("strobe without a completed transfer");

  // Control levels follow the written configuration
  a_irq_follow: assert property (wrDone && sel == dcfi_pkg::SEL_CONFIG_REG_ONE // R13
    |=> irqEnable == |($past(apbReq.pwdata[15:0]) & dcfi_pkg::CONFIG_REG_ONE_IRQ_MASK))
    else $error("interrupt enable does not follow config one");
  a_dma_follow: assert property (wrDone && sel == dcfi_pkg::SEL_CONFIG_REG_ONE // R13
    |=> dmaEnable == |($past(apbReq.pwdata[15:0]) & dcfi_pkg::CONFIG_REG_ONE_DMA_MASK))
    else $error("DMA enable does not follow config one");
  a_dio_follow: assert property (wrDone && sel == dcfi_pkg::SEL_CONFIG_REG_THREE // R14
    |=> dioOutEn_n != $past(apbReq.pwdata[dcfi_pkg::CONFIG_REG_THREE_DIO_BIT]))
    else $error("digital line enable does not follow config three");
  a_cal_follow: assert property (wrDone && sel == dcfi_pkg::SEL_CONFIG_REG_THREE // R14
    |=> calEnable == $past(apbReq.pwdata[dcfi_pkg::CONFIG_REG_THREE_CAL_BIT]))
    else $error("calibration does not follow config three");
  a_counter_low: assert property (wrDone && sel == dcfi_pkg::SEL_CNTCMD && cntSel == 2'h1 // R14
    && apbReq.pwdata[dcfi_pkg::CMD_MODE_HI:dcfi_pkg::CMD_MODE_LO] == dcfi_pkg::MODE_LOW_OUT
    |=> !counterOneOut)
    else $error("counter one output not low");
  a_counter_two: assert property (wrDone && sel == dcfi_pkg::SEL_CNTCMD && cntSel == 2'h2 // R14
    && apbReq.pwdata[dcfi_pkg::CMD_MODE_HI:dcfi_pkg::CMD_MODE_LO] != dcfi_pkg::MODE_LOW_OUT
    |=> counterTwoOut)
    else $error("counter two output not high");

  // Reset values, last channel and strap synchroniser
  a_reset_ctl: assert property ($rose(rst_n) |-> !irqEnable && !dmaEnable && !calEnable // R9
    && dioOutEn_n && counterOneOut && counterTwoOut)
    else $error("control outputs not at reset levels");
  a_reset_level: assert property ($rose(rst_n) |=> dacLevel[0] == 13'(dcfi_pkg::CODE_MID)) // R10
    else $error("channel level not mid-scale after reset");
  a_code_last: assert property (wrDone && sel == dcfi_pkg::SEL_CODE && chIdx == 8'(NCH - 1) // R3
    |=> st_q.code[NCH-1] == $past(apbReq.pwdata[dcfi_pkg::CODE_W-1:0]))
    else $error("last channel code not stored");
  a_strap_agree: assert property ($changed(st_q.bipolar)
    |-> ((st_q.bipolar ^ $past(st_q.bipolar)) & ($past(st_q.sync2) ^ $past(st_q.sync3))) == '0
    && ((st_q.bipolar ^ $past(st_q.bipolar)) & (st_q.bipolar ^ $past(st_q.sync3))) == '0)
    else $error("strap changed before its stages agreed");

  c_init_write: cover property (wrDone && sel == dcfi_pkg::SEL_CONFIG_REG_ONE ##[1:20] wrDone && sel == dcfi_pkg::SEL_CNTCMD);
  c_queue_clear: cover property (rdDone && sel == dcfi_pkg::SEL_QCLR);
  c_code_write: cover property (wrDone && sel == dcfi_pkg::SEL_CODE);
  c_strap_change: cover property ($changed(st_q.bipolar));
  c_bad_addr: cover property (access && sel == dcfi_pkg::SEL_NONE);

endmodule
`default_nettype wire

/* File: core/dcfi_unused_placeholder_none.sv */
`default_nettype none
`default_nettype wire

/* File: testbench/dcfi_host_model.sv */
`default_nettype none
module dcfi_host_model
(
  // Clock
  input  wire logic                    sys_clk,
  // APB master side
  output dcfi_pkg::dcfi_apb_req_t      apbReq,
  input  wire dcfi_pkg::dcfi_apb_rsp_t apbRsp
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Bus idle at time zero
  initial apbReq = '0;

  // One whole-word transfer: setup, access held until pready, then release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic ok);
    int n;
    apbReq <= '{1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (apbRsp.pready !== 1'b1 && n < 50);
    ok = (n < 50);
    rd = apbRsp.prdata;
    // Released lines carry the inverse so stale values never look valid
    apbReq <= '{1'b0, 1'b0, ~wr, ~a, ~d};
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* File: testbench/test_dac_code_format_and_init.sv */
`default_nettype none
module test_dac_code_format_and_init;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = 10;
  typedef struct packed {logic err; logic [31:0] data; logic [31:0] mask;} dcfi_note_t;

  logic                                         sys_clk = 1'b0;
  logic                                         rst_n = 1'b0;
  logic [NCH-1:0]                               bipolarPin;
  dcfi_pkg::dcfi_apb_req_t                      apbReq;
  dcfi_pkg::dcfi_apb_rsp_t                      apbRsp;
  logic signed [NCH-1:0][dcfi_pkg::LEVEL_W-1:0] dacLevel;
  logic                                         irqEnable, dmaEnable, dioOutEn_n;
  logic                                         calEnable, counterOneOut, counterTwoOut;
  dcfi_pkg::dcfi_strobe_t                       strobes;
  dcfi_pkg::dcfi_strobe_t                       pulses[$];
  dcfi_note_t                                   notes[$];
  dcfi_note_t                                   note;
  logic [NCH-1:0]                               twos = '0;
  logic [11:0]                                  codes[NCH];
  logic [11:0]                                  tbl[6] = '{12'h000, 12'h001, 12'h7FF, 12'h800, 12'h801, 12'hFFF};
  int                                           err_total = 0;
  int                                           comparisons = 0;

  always #10 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  dcfi_core #(.NCH(NCH)) i_dcfi_core (.sys_clk(sys_clk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
    .bipolarPin(bipolarPin), .dacLevel(dacLevel), .irqEnable(irqEnable), .dmaEnable(dmaEnable),
    .dioOutEn_n(dioOutEn_n), .calEnable(calEnable), .counterOneOut(counterOneOut),
    .counterTwoOut(counterTwoOut), .strobes(strobes));
  dcfi_host_model i_dcfi_host_model (.sys_clk(sys_clk), .apbReq(apbReq), .apbRsp(apbRsp));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected level: offset form first, then bipolar shifts zero to mid code
  function automatic logic [12:0] lvl(logic [11:0] c, logic tc, logic bp);
    logic [12:0] u;
    u = {1'b0, tc ? c ^ 12'h800 : c};
    return bp ? u - 13'h0800 : u;
  endfunction

  // Notes the answer and strobe expected, then runs the transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0]            rd;
    logic                   ok;
    dcfi_pkg::dcfi_strobe_t s;
    s = {!wr && a == dcfi_pkg::ADDR_QCLR, wr && a == dcfi_pkg::ADDR_IRQ1CL,
         wr && a == dcfi_pkg::ADDR_IRQ2CL, wr && a == dcfi_pkg::ADDR_DMATCL};
    if (s != 4'h0)
      pulses.push_back(s);
    notes.push_back('{err, exp, mask});
    i_dcfi_host_model.xfer(wr, a, d, rd, ok);
    if (!ok)
    begin
      err_total++;
      conclude();
    end
  endtask

  task automatic ctl(input logic [5:0] e);
    cmp({26'h0, irqEnable, dmaEnable, dioOutEn_n, calEnable, counterOneOut, counterTwoOut}, {26'h0, e});
  endtask

  task automatic levels;
    for (int i = 0; i < NCH; i++)
      cmp({19'h0, dacLevel[i]}, {19'h0, lvl(codes[i], twos[i], bipolarPin[i])});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Answer and strobe monitor
  always @(posedge sys_clk)
  begin
    if (apbRsp.pready === 1'b1)
    begin
      note = (notes.size() > 0) ? notes.pop_front() : '{1'b1, 32'hFFFFFFFF, 32'h0};
      cmp({31'h0, apbRsp.pslverr}, {31'h0, note.err});
      cmp(apbRsp.prdata & note.mask, note.data & note.mask);
    end
    if (rst_n && strobes !== 4'h0)
      cmp({28'h0, strobes}, {28'h0, (pulses.size() > 0) ? pulses.pop_front() : 4'h0});
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    void'($urandom(9));
    bipolarPin <= NCH'($urandom);
    foreach (codes[i]) codes[i] = dcfi_pkg::CODE_MID;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    ctl(6'b001011);
    levels();
    bus(1'b1, dcfi_pkg::ADDR_CONFIG_REG_ONE, 32'h00F0, 1'b0, 32'h0, 32'h0);
    ctl(6'b101011);
    bus(1'b1, dcfi_pkg::ADDR_CONFIG_REG_ONE, 32'h0300, 1'b0, 32'h0, 32'h0);
    ctl(6'b011011);
    bus(1'b0, dcfi_pkg::ADDR_CONFIG_REG_ONE, 32'h0, 1'b0, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, dcfi_pkg::ADDR_CONFIG_REG_THREE, 32'h0003, 1'b0, 32'h0, 32'h0);
    bus(1'b1, dcfi_pkg::ADDR_CNTCMD, 32'h40, 1'b0, 32'h0, 32'h0);
    bus(1'b1, dcfi_pkg::ADDR_CNTCMD, 32'h80, 1'b0, 32'h0, 32'h0);
    ctl(6'b010100);
    bus(1'b1, dcfi_pkg::ADDR_CNTCMD, 32'h42, 1'b0, 32'h0, 32'h0);
    bus(1'b1, dcfi_pkg::ADDR_CNTCMD, 32'h82, 1'b0, 32'h0, 32'h0);
    bus(1'b1, dcfi_pkg::ADDR_CODE0 + 8'(4 * NCH), 32'h0, 1'b1, 32'h0, 32'h0);
    bus(1'b0, dcfi_pkg::ADDR_CODE0 + 8'(4 * NCH), 32'h0, 1'b1, 32'h0, 32'h0);
    // Code formats over table corners and random codes
    for (int r = 0; r < 10; r++)
    begin
      twos = NCH'($urandom);
      bus(1'b1, dcfi_pkg::ADDR_CONFIG_REG_TWO, 32'(twos), 1'b0, 32'h0, 32'h0);
      for (int i = 0; i < NCH; i++)
      begin
        codes[i] = (r < 6) ? tbl[r] : 12'($urandom);
        bus(1'b1, dcfi_pkg::ADDR_CODE0 + 8'(4 * i),
            {16'h0, twos[i] ? {4{codes[i][11]}} : 4'h0, codes[i]}, 1'b0, 32'h0, 32'h0);
      end
      if (r == 7)
      begin
        bipolarPin <= ~bipolarPin;
        repeat (8) @(posedge sys_clk);
      end
      @(posedge sys_clk);
      levels();
    end
    // Reset in mid-run restores the power-up state
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    twos = '0;
    foreach (codes[i]) codes[i] = dcfi_pkg::CODE_MID;
    repeat (8) @(posedge sys_clk);
    ctl(6'b001011);
    levels();
    // Software initialisation
    bus(1'b1, dcfi_pkg::ADDR_CONFIG_REG_ONE, 32'd0, 1'b0, 32'h0, 32'h0);
    bus(1'b1, dcfi_pkg::ADDR_CNTCMD, 32'd18, 1'b0, 32'h0, 32'h0);
    bus(1'b1, dcfi_pkg::ADDR_CNT1LD, 32'd3, 1'b0, 32'h0, 32'h0);
    bus(1'b1, dcfi_pkg::ADDR_CNTCMD, 32'd58, 1'b0, 32'h0, 32'h0);
    bus(1'b1, dcfi_pkg::ADDR_CONFIG_REG_TWO, 32'd0, 1'b0, 32'h0, 32'h0);
    bus(1'b1, dcfi_pkg::ADDR_CONFIG_REG_THREE, 32'd0, 1'b0, 32'h0, 32'h0);
    bus(1'b0, dcfi_pkg::ADDR_QCLR, 32'd0, 1'b0, 32'h0, 32'h0);
    bus(1'b1, dcfi_pkg::ADDR_CONFIG_REG_ONE, 32'd80, 1'b0, 32'h0, 32'h0);
    ctl(6'b101011);
    bus(1'b1, dcfi_pkg::ADDR_IRQ1CL, 32'd0, 1'b0, 32'h0, 32'h0);
    bus(1'b1, dcfi_pkg::ADDR_IRQ2CL, 32'd0, 1'b0, 32'h0, 32'h0);
    bus(1'b1, dcfi_pkg::ADDR_DMATCL, 32'd0, 1'b0, 32'h0, 32'h0);
    bus(1'b1, dcfi_pkg::ADDR_CONFIG_REG_ONE, 32'd0, 1'b0, 32'h0, 32'h0);
    ctl(6'b001011);
    bus(1'b0, dcfi_pkg::ADDR_STATUS, 32'h0, 1'b0, 32'({bipolarPin, 3'b111}), 32'((1 << (NCH + 3)) - 1));
    twos = '0;
    @(posedge sys_clk);
    levels();
    repeat (4) @(posedge sys_clk);
    cmp(32'(notes.size() + pulses.size()), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
